// ### fbir_defs.vh
`ifndef FBIR_DEFS_VH
`define FBIR_DEFS_VH

// clock period of the controller
`define FBIR_CLK_NS        16'h0014

// flash pin timing, in ns (least times, rounded up to whole cycles)
`define FBIR_T_RST_PULSE_NS   16'h0064
`define FBIR_T_RST_READ_NS    16'h0096
`define FBIR_T_RST_WRITE_NS   16'h0064
`define FBIR_T_ABORT_NS       16'h4E20
`define FBIR_T_ACCESS_NS      16'h0050
`define FBIR_T_WE_PULSE_NS    16'h003C
`define FBIR_T_SETUP_NS       16'h0014
`define FBIR_T_HOLD_NS        16'h0014

// kept 16 bits wide so the counts meet the 16-bit counters without truncation
`define FBIR_CYC(ns) (((ns) + `FBIR_CLK_NS - 16'h0001) / `FBIR_CLK_NS)

`define FBIR_RST_PULSE_CYC  `FBIR_CYC(`FBIR_T_RST_PULSE_NS)
`define FBIR_RST_READ_CYC   `FBIR_CYC(`FBIR_T_RST_READ_NS)
`define FBIR_RST_WRITE_CYC  `FBIR_CYC(`FBIR_T_RST_WRITE_NS)
`define FBIR_ABORT_CYC      `FBIR_CYC(`FBIR_T_ABORT_NS)
`define FBIR_ACCESS_CYC     `FBIR_CYC(`FBIR_T_ACCESS_NS)
`define FBIR_WE_PULSE_CYC   `FBIR_CYC(`FBIR_T_WE_PULSE_NS)
`define FBIR_SETUP_CYC      `FBIR_CYC(`FBIR_T_SETUP_NS)
`define FBIR_HOLD_CYC       `FBIR_CYC(`FBIR_T_HOLD_NS)

// register byte offsets on the AXI4-Lite slave
`define FBIR_REG_CMD     8'h00
`define FBIR_REG_ADDR    8'h04
`define FBIR_REG_WDATA   8'h08
`define FBIR_REG_STATUS  8'h0C
`define FBIR_REG_RDATA   8'h10

// command register fields
`define FBIR_CMD_OP_LSB   0
`define FBIR_CMD_OP_MSB   1
`define FBIR_CMD_OFS_LSB  8
`define FBIR_CMD_OFS_MSB  15

// operation codes
`define FBIR_OP_READ      2'h0
`define FBIR_OP_WRITE     2'h1
`define FBIR_OP_RESET     2'h2
`define FBIR_OP_IDREAD    2'h3

// status register bits
`define FBIR_ST_BUSY      0
`define FBIR_ST_READ_OK   1
`define FBIR_ST_WRITE_OK  2
`define FBIR_ST_IDENT     3
`define FBIR_ST_ARRAY     4

// flash command codes
`define FBIR_FCMD_ARRAY   16'h00FF
`define FBIR_FCMD_IDENT   16'h0090

// identifier offsets from a block base
`define FBIR_ID_MAKER     8'h00
`define FBIR_ID_PART      8'h01
`define FBIR_ID_LOCK      8'h02
`define FBIR_ID_OTP_LOCK  8'h80
`define FBIR_ID_OTP_DATA  8'h81
`define FBIR_ID_OTP_LAST  8'h88

// lock state bits in the word read at the lock offset
`define FBIR_LOCK_BIT     0
`define FBIR_LOCKDOWN_BIT 1

`define FBIR_AXI_OKAY     2'h0
`define FBIR_AXI_SLVERR   2'h2

`endif

// ### fbir_host.v
`timescale 1ns/1ps
`include "fbir_defs.vh"

module fbir_host (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // flash control pins
  output reg         chip_sel_n,
  output reg         out_en_n,
  output reg         wr_en_n,
  output reg         reset_powerdown_n,
  output reg  [21:0] flash_addr,
  // flash data pins, three signals each
  input  wire [15:0] dq_in,
  output reg  [15:0] dq_out,
  output reg         dq_oe
);
  // the abort shutdown may outlast the pulse; the remainder is waited after release
  localparam [15:0] PULSE_CYC  = `FBIR_RST_PULSE_CYC;
  localparam [15:0] ABORT_CYC  = `FBIR_ABORT_CYC;
  localparam [15:0] ABORT_REST = (ABORT_CYC > PULSE_CYC) ? (ABORT_CYC - PULSE_CYC) : 16'h0000;
  localparam [15:0] READ_GATE  = ABORT_REST + `FBIR_RST_READ_CYC;
  localparam [15:0] WRITE_GATE = ABORT_REST + `FBIR_RST_WRITE_CYC;
  localparam [15:0] ACC_CYC    = `FBIR_ACCESS_CYC;
  localparam [15:0] WEP_CYC    = `FBIR_WE_PULSE_CYC;
  localparam [15:0] SETUP_CYC  = `FBIR_SETUP_CYC;
  localparam [15:0] HOLD_CYC   = `FBIR_HOLD_CYC;
  // one-hot flash sequencer states
  localparam [6:0] S_IDLE    = 7'h01;
  localparam [6:0] S_RST_LOW = 7'h02;
  localparam [6:0] S_RD      = 7'h04;
  localparam [6:0] S_RD_END  = 7'h08;
  localparam [6:0] S_WR_SET  = 7'h10;
  localparam [6:0] S_WR_PLS  = 7'h20;
  localparam [6:0] S_WR_HLD  = 7'h40;
  // byte-lane merge for writable registers
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer i;
    begin
      lane_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction
  reg [31:0] cmd_reg;
  reg [31:0] addr_reg;
  reg [31:0] wdata_reg;
  reg [15:0] rdata_reg;
  reg        op_pending;
  reg        ident_mode;
  reg        array_mode;
  reg [6:0]  state;
  reg [15:0] cnt;
  reg [15:0] since_rel;
  reg [7:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire [1:0] op       = cmd_reg[`FBIR_CMD_OP_MSB:`FBIR_CMD_OP_LSB];
  wire [7:0] id_ofs   = (op == `FBIR_OP_IDREAD) ?
                        cmd_reg[`FBIR_CMD_OFS_MSB:`FBIR_CMD_OFS_LSB] : 8'h00;
  wire       read_ok  = (since_rel >= READ_GATE);
  wire       write_ok = (since_rel >= WRITE_GATE);
  wire       busy     = op_pending | (state != S_IDLE);
  wire       wr_do    = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire       cmd_hit  = wr_do & (aw_addr == `FBIR_REG_CMD) & ~busy;
  wire [31:0] status_word = {27'h0000000, array_mode, ident_mode, write_ok, read_ok, busy};

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FBIR_AXI_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `FBIR_REG_CMD, `FBIR_REG_ADDR, `FBIR_REG_WDATA,
          `FBIR_REG_STATUS, `FBIR_REG_RDATA: s_axi_bresp <= `FBIR_AXI_OKAY;
          default: s_axi_bresp <= `FBIR_AXI_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // writable registers; a command written while busy is dropped
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg   <= 32'h00000000;
      addr_reg  <= 32'h00000000;
      wdata_reg <= 32'h00000000;
    end else if (wr_do) begin
      case (aw_addr)
        `FBIR_REG_CMD: begin
          if (!busy) begin
            cmd_reg <= lane_merge(cmd_reg, w_data, w_strb);
          end
        end
        `FBIR_REG_ADDR:  addr_reg  <= lane_merge(addr_reg, w_data, w_strb);
        `FBIR_REG_WDATA: wdata_reg <= lane_merge(wdata_reg, w_data, w_strb);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel: data one cycle after the address is taken
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `FBIR_AXI_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `FBIR_AXI_OKAY;
        case (s_axi_araddr)
          `FBIR_REG_CMD:    s_axi_rdata <= cmd_reg;
          `FBIR_REG_ADDR:   s_axi_rdata <= addr_reg;
          `FBIR_REG_WDATA:  s_axi_rdata <= wdata_reg;
          `FBIR_REG_STATUS: s_axi_rdata <= status_word;
          `FBIR_REG_RDATA:  s_axi_rdata <= {16'h0000, rdata_reg};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FBIR_AXI_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time since reset release; a conservative gate that also covers a
  // possible abort shutdown, since the host cannot see whether one ran
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since_rel <= 16'h0000;
    end else if (state == S_RST_LOW) begin
      since_rel <= 16'h0000;
    end else if (!(read_ok && write_ok)) begin
      since_rel <= since_rel + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash sequencer; pins idle deselected with data floating
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state             <= S_RST_LOW;
      cnt               <= 16'h0000;
      op_pending        <= 1'b0;
      chip_sel_n        <= 1'b1;
      out_en_n          <= 1'b1;
      wr_en_n           <= 1'b1;
      reset_powerdown_n <= 1'b0;
      flash_addr        <= 22'h000000;
      dq_out            <= 16'h0000;
      dq_oe             <= 1'b0;
      rdata_reg         <= 16'h0000;
      ident_mode        <= 1'b0;
      array_mode        <= 1'b1;
    end else begin
      if (cmd_hit) begin
        op_pending <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          chip_sel_n <= 1'b1;
          out_en_n   <= 1'b1;
          wr_en_n    <= 1'b1;
          dq_oe      <= 1'b0;
          if (op_pending) begin
            case (op)
              `FBIR_OP_RESET: begin
                op_pending        <= 1'b0;
                reset_powerdown_n <= 1'b0;
                state             <= S_RST_LOW;
              end
              `FBIR_OP_WRITE: begin
                if (write_ok) begin
                  op_pending <= 1'b0;
                  flash_addr <= addr_reg[21:0];
                  dq_out     <= wdata_reg[15:0];
                  chip_sel_n <= 1'b0;
                  state      <= S_WR_SET;
                end
              end
              default: begin
                if (read_ok) begin
                  op_pending <= 1'b0;
                  flash_addr <= addr_reg[21:0] + {14'h0000, id_ofs};
                  chip_sel_n <= 1'b0;
                  out_en_n   <= 1'b0;
                  state      <= S_RD;
                end
              end
            endcase
          end
        end
        S_RST_LOW: begin
          // whole pulse held; pins stay quiet from idle or reset; shutdown rest waited later
          cnt        <= cnt + 16'h0001;
          if (cnt >= PULSE_CYC - 16'h0001) begin
            reset_powerdown_n <= 1'b1;
            ident_mode        <= 1'b0;
            array_mode        <= 1'b1;
            cnt               <= 16'h0000;
            state             <= S_IDLE;
          end
        end
        S_RD: begin
          cnt <= cnt + 16'h0001;
          if (cnt >= ACC_CYC - 16'h0001) begin
            rdata_reg <= dq_in;
            chip_sel_n <= 1'b1;
            out_en_n   <= 1'b1;
            cnt        <= 16'h0000;
            state      <= S_RD_END;
          end
        end
        S_RD_END: begin
          // one quiet cycle so the flash releases the bus before we may drive it
          state <= S_IDLE;
        end
        S_WR_SET: begin
          // output enable stays high for the whole write
          dq_oe <= 1'b1;
          cnt   <= cnt + 16'h0001;
          if (cnt >= SETUP_CYC - 16'h0001) begin
            wr_en_n <= 1'b0;
            cnt     <= 16'h0000;
            state   <= S_WR_PLS;
          end
        end
        S_WR_PLS: begin
          cnt <= cnt + 16'h0001;
          if (cnt >= WEP_CYC - 16'h0001) begin
            // write enable rises first with data still stable: the latch edge
            wr_en_n <= 1'b1;
            cnt     <= 16'h0000;
            state   <= S_WR_HLD;
          end
        end
        S_WR_HLD: begin
          cnt <= cnt + 16'h0001;
          if (cnt >= HOLD_CYC - 16'h0001) begin
            // deselect does not stop a started program or erase
            chip_sel_n <= 1'b1;
            dq_oe      <= 1'b0;
            cnt        <= 16'h0000;
            state      <= S_IDLE;
            array_mode <= (dq_out == `FBIR_FCMD_ARRAY);
            ident_mode <= (dq_out == `FBIR_FCMD_IDENT);
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // fbir_host

// ### fbir_host_assertions.sv
`timescale 1ns/1ps
`include "fbir_defs.vh"
module fbir_chk (
  // clock and reset
  input wire        clk,
  input wire        arst_n,
  // flash pins
  input wire        chip_sel_n,
  input wire        out_en_n,
  input wire        wr_en_n,
  input wire        reset_powerdown_n,
  input wire        dq_oe
);
  localparam int RD_GATE = `FBIR_ABORT_CYC - `FBIR_RST_PULSE_CYC + `FBIR_RST_READ_CYC;
  localparam int WR_GATE = `FBIR_ABORT_CYC - `FBIR_RST_PULSE_CYC + `FBIR_RST_WRITE_CYC;
  reg [11:0] since_rel;
  //////////////////////////////////////////////////////////////////////////////
  // cycles since flash reset release; saturates so it never wraps into a false failure
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      since_rel <= 12'h000;
    else if (!reset_powerdown_n)
      since_rel <= 12'h000;
    else if (since_rel != 12'hFFF)
      since_rel <= since_rel + 12'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////////////
  property p_read_pins; !out_en_n |-> !chip_sel_n && wr_en_n && reset_powerdown_n; endproperty
  a_read_pins: assert property (p_read_pins) else $error("bad read pins");
  property p_write_pins; !wr_en_n |-> !chip_sel_n && out_en_n && reset_powerdown_n; endproperty
  a_write_pins: assert property (p_write_pins) else $error("bad write pins");
  property p_we_edge; $rose(wr_en_n) |-> !chip_sel_n && dq_oe; endproperty
  a_we_edge: assert property (p_we_edge) else $error("data gone at strobe");
  property p_no_fight; !out_en_n |-> !dq_oe; endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus fight");
  property p_standby; chip_sel_n |-> out_en_n && wr_en_n; endproperty
  a_standby: assert property (p_standby) else $error("strobe while idle");
  property p_read_len; $fell(out_en_n) |-> !out_en_n [*4] ##1 out_en_n; endproperty
  a_read_len: assert property (p_read_len) else $error("read length");
  property p_rst_len; $fell(reset_powerdown_n) |-> !reset_powerdown_n [*5]; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse short");
  property p_rst_quiet; !reset_powerdown_n |-> chip_sel_n && wr_en_n && !dq_oe; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("active in reset");
  property p_rd_gate; $fell(out_en_n) |-> since_rel >= RD_GATE; endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("read too early");
  property p_wr_gate; $fell(wr_en_n) |-> since_rel >= WR_GATE; endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write too early");
endmodule // fbir_chk
bind fbir_host fbir_chk fbir_chk_i (.clk(clk), .arst_n(arst_n), .chip_sel_n(chip_sel_n),
  .out_en_n(out_en_n), .wr_en_n(wr_en_n), .reset_powerdown_n(reset_powerdown_n), .dq_oe(dq_oe));

// ### fbir_flash_model.sv
`timescale 1ns/1ps
module fbir_flash_model #(
  parameter [15:0] MAKER = 16'h5A01, // arbitrary value
  parameter [15:0] PART  = 16'h5A02  // arbitrary value
) (
  // flash pins
  input  wire        chip_sel_n,
  input  wire        out_en_n,
  input  wire        wr_en_n,
  input  wire        reset_powerdown_n,
  input  wire [21:0] flash_addr,
  input  wire [15:0] dq_out,
  input  wire        dq_oe,
  output reg  [15:0] dq_in
);
  reg        ident = 1'b0;
  reg [15:0] lock_word = 16'h0000;
  reg [15:0] drv;
  //////////////////////////////////////////////////////////////////////////////
  // commands latch on the first rising strobe; codes other than 90 count as array
  always @(posedge wr_en_n or posedge chip_sel_n or negedge reset_powerdown_n) begin
    if (!reset_powerdown_n) begin
      ident     <= 1'b0;
      lock_word <= 16'h0001;
    end else if ((!chip_sel_n || !wr_en_n) && out_en_n && dq_oe)
      ident <= (dq_out == 16'h0090);
  end
  // word for the current address; a released bus shows its inverse
  always @* begin
    case (flash_addr[7:0])
      8'h00:   drv = MAKER;
      8'h01:   drv = PART;
      8'h02:   drv = lock_word;
      8'h80:   drv = 16'h0002;
      default: drv = 16'hD000 | {8'h00, flash_addr[7:0]};
    endcase
    if (!ident)
      drv = flash_addr[15:0] ^ 16'hC35A;
    dq_in = (!chip_sel_n && !out_en_n && reset_powerdown_n) ? drv : ~drv;
  end
endmodule // fbir_flash_model

// ### test_fbir_host.sv
`timescale 1ns/1ps
`include "fbir_defs.vh"
module test_fbir_host;
  localparam [15:0] MAKER = 16'h5A01; // arbitrary value
  localparam [15:0] PART  = 16'h5A02; // arbitrary value
  reg         clk = 1'b0, arst_n = 1'b0;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [31:0] wdata = 32'h0, rd;
  reg  [3:0]  wstrb = 4'hF;
  reg  [1:0]  rs;
  reg  [21:0] a;
  wire        awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, rp_n, dq_oe;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [21:0] fa;
  wire [15:0] dq_in, dq_out;
  int         num_errors = 0, checks = 0, i;
  always #10 clk = ~clk;
  fbir_host fbir_host_i (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chip_sel_n(ce_n), .out_en_n(oe_n), .wr_en_n(we_n),
    .reset_powerdown_n(rp_n), .flash_addr(fa), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  fbir_flash_model #(.MAKER(MAKER), .PART(PART)) fbir_flash_model_i (.chip_sel_n(ce_n),
    .out_en_n(oe_n), .wr_en_n(we_n), .reset_powerdown_n(rp_n), .flash_addr(fa),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input [31:0] got, input [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // each task lets one edge pass at its end so strobes never change twice at once
  task automatic wr(input [7:0] ad, input [31:0] d);
    int n;
    n = 0;
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 500);
    rs = bresp;
    bready <= 1'b0;
    check(n < 500, 1'b1);
    @(posedge clk);
  endtask
  task automatic rd_reg(input [7:0] ad);
    int n;
    n = 0;
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 500);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    check(n < 500, 1'b1);
    @(posedge clk);
  endtask
  // start an operation and poll busy under a bound
  task automatic op(input [1:0] o, input [7:0] ofs);
    int n;
    n = 0;
    wr(`FBIR_REG_CMD, {16'h0000, ofs, 6'h00, o});
    do begin
      rd_reg(`FBIR_REG_STATUS);
      n++;
    end while (rd[`FBIR_ST_BUSY] && n < 3000);
    check(n < 3000, 1'b1);
  endtask
  task automatic fread(input [21:0] ad, input [1:0] o, input [7:0] ofs, input [15:0] exp);
    wr(`FBIR_REG_ADDR, {10'h000, ad});
    check(rs, `FBIR_AXI_OKAY);
    op(o, ofs);
    rd_reg(`FBIR_REG_RDATA);
    check(rs, `FBIR_AXI_OKAY);
    check(rd, {16'h0000, exp});
  endtask
  task automatic fcmd(input [15:0] c);
    wr(`FBIR_REG_WDATA, {16'h0000, c});
    op(`FBIR_OP_WRITE, 8'h00);
  endtask
  function automatic [15:0] exp_id(input [7:0] o);
    exp_id = (o == 8'h00) ? MAKER : (o == 8'h01) ? PART : (o == 8'h02) ? 16'h0001 :
             (o == 8'h80) ? 16'h0002 : 16'hD000 | {8'h00, o};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("num_errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // main sequence: array reads, identifier space, mode switches, reset op
  initial begin
    rd = $urandom(70643);
    repeat (16) @(posedge clk);
    check(rp_n, 1'b0);
    arst_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      a = $urandom;
      fread(a, `FBIR_OP_READ, 8'h00, a[15:0] ^ 16'hC35A);
    end
    rd_reg(`FBIR_REG_STATUS);
    check(rd[`FBIR_ST_ARRAY], 1'b1);
    fcmd(`FBIR_FCMD_IDENT);
    rd_reg(`FBIR_REG_STATUS);
    check(rd[`FBIR_ST_IDENT], 1'b1);
    a = $urandom & 22'h3FF000;
    for (i = 0; i < 12; i++)
      fread(a, `FBIR_OP_IDREAD, (i < 3) ? i : 8'h7D + i, exp_id((i < 3) ? i : 8'h7D + i));
    fcmd(`FBIR_FCMD_ARRAY);
    fread(a + 22'h2, `FBIR_OP_READ, 8'h00, (a[15:0] + 16'h2) ^ 16'hC35A);
    fcmd(`FBIR_FCMD_IDENT);
    op(`FBIR_OP_RESET, 8'h00);
    rd_reg(`FBIR_REG_STATUS);
    check(rd[`FBIR_ST_WRITE_OK:`FBIR_ST_READ_OK], 2'b00);
    check(rd[`FBIR_ST_ARRAY:`FBIR_ST_IDENT], 2'b10);
    fread(a + 22'h1, `FBIR_OP_READ, 8'h00, (a[15:0] + 16'h1) ^ 16'hC35A);
    fcmd(`FBIR_FCMD_IDENT);
    fread(a, `FBIR_OP_IDREAD, `FBIR_ID_LOCK, 16'h0001);
    wr(8'h20, 32'h0);
    check(rs, `FBIR_AXI_SLVERR);
    rd_reg(8'h20);
    check(rs, `FBIR_AXI_SLVERR);
    check(rd, 32'h00000000);
    // single-lane write keeps the upper bytes of the block base
    wstrb <= 4'h1;
    wr(`FBIR_REG_ADDR, 32'hFFFFFF5A);
    wstrb <= 4'hF;
    rd_reg(`FBIR_REG_ADDR);
    check(rd, {10'h000, a[21:8], 8'h5A});
    give_verdict;
  end
  // watchdog well beyond the few reset gates of the sequence
  initial begin
    #1000000;
    num_errors++;
    give_verdict;
  end
endmodule // test_fbir_host
